/* hdl/backlight_ctrl_pkg.sv */
// Shared constants, register map and types of the backlight mode, gain and scaling controller.
package backlight_ctrl_pkg;
    localparam int CLK_PERIOD_NS = 25;
    localparam int RST_FILTER_NS = 50000;
    localparam int RST_FILTER_CYC = (RST_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int GAIN_SETTLE_NS = 100000;
    localparam int GAIN_SETTLE_CYC = (GAIN_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 12;
    localparam logic [CNT_W-1:0] RST_FILTER_CNT = CNT_W'(RST_FILTER_CYC);
    localparam logic [CNT_W-1:0] GAIN_SETTLE_CNT = CNT_W'(GAIN_SETTLE_CYC);
    localparam int PWM_WIN_LOG2 = 12;
    localparam logic [PWM_WIN_LOG2-1:0] PWM_WIN_LAST = 12'hfff;
    localparam logic [PWM_WIN_LOG2:0] PWM_FULL = 13'h1000;
    localparam int NUM_SINKS = 7;
    localparam int CODE_W = 7;
    localparam int SYNC_W = 7 + 2 * NUM_SINKS;
    localparam logic [3:0] I2C_BYTE_BITS = 4'h8;
    localparam logic [3:0] I2C_LAST_BIT = 4'h7;
    // Device address on the serial bus; the value is arbitrary.
    localparam logic [6:0] I2C_DEV_ADDR = 7'h2b;
    localparam logic [7:0] REG_MODE_CTRL = 8'h01;
    localparam logic [7:0] REG_IMG_SCALE_SEL = 8'h06;
    localparam logic [7:0] REG_LED_LEVEL = 8'h0a;
    localparam logic [7:0] REG_SINK_ENABLE = 8'h1d;
    localparam logic [7:0] REG_STATUS = 8'h1e;
    localparam int ACTIVE_BIT_POS = 0;
    localparam logic [7:0] MODE_CTRL_RST = 8'h00;
    localparam logic [NUM_SINKS-1:0] IMG_SEL_RST = 7'h00;
    localparam logic [NUM_SINKS-1:0] SINK_EN_RST = 7'h7f;
    localparam logic [CODE_W-1:0] LED_LEVEL_RST = 7'h00;

    typedef enum logic [4:0] {
        MODE_SHUTDOWN = 5'b00001,
        MODE_POR = 5'b00010,
        MODE_STANDBY = 5'b00100,
        MODE_SOFTSTART = 5'b01000,
        MODE_ACTIVE = 5'b10000
    } op_mode_type;

    typedef enum logic [2:0] {
        GAIN_1X = 3'b001,
        GAIN_1P5X = 3'b010,
        GAIN_2X = 3'b100
    } gain_type;

    typedef enum logic [8:0] {
        I2C_IDLE = 9'b000000001,
        I2C_ADDR = 9'b000000010,
        I2C_ADDR_ACK = 9'b000000100,
        I2C_PTR = 9'b000001000,
        I2C_PTR_ACK = 9'b000010000,
        I2C_WR = 9'b000100000,
        I2C_WR_ACK = 9'b001000000,
        I2C_RD = 9'b010000000,
        I2C_RD_ACK = 9'b100000000
    } i2c_state_type;

    typedef struct packed {
        logic bypass;
        logic charge_series;
        logic charge_parallel;
        logic discharge_parallel;
    } cp_switch_type;

    typedef struct packed {
        logic [NUM_SINKS-1:0] below_min;
        logic [NUM_SINKS-1:0] above_max;
    } headroom_type;

    typedef logic [NUM_SINKS-1:0][CODE_W-1:0] sink_codes_type;
endpackage

/* hdl/backlight_mode_ctrl.sv */
// Mode sequencing, charge-pump gain control, serial register access and image PWM current scaling.
//
// Contract
// - Setting the active-mode bit brings the device into active operation.
// - Standby turns everything off except the serial receivers.
// - Clearing the active-mode bit or a long reset-pin low forces standby.
// - Every exit from standby to active passes through soft start first; undervoltage goes straight to shutdown.
// - Undervoltage means shutdown with serial port off; recovery resets registers, then standby.
// - Leaving shutdown always runs power-on reset and lands in standby.
// - Reset pin low: standby, registers held at default, no acknowledge.
// - After reset pin release: defaults kept, standby, serial commands accepted again.
// - Reset pin low pulses shorter than the filter time are ignored.
// - Gain starts at unity when operation begins.
// - Any enabled sink short of headroom raises the gain one step.
// - Each gain change is followed by a settle wait before deciding again.
// - All enabled sinks above maximum headroom lowers the gain one step.
// - Disabled sinks are ignored by gain decisions.
// - Soft start charges with limited current until the 92 percent comparator trips.
// - Switch network follows gain: bypass, series-charge, or parallel-charge.
// - A fault opens every charge-pump switch.
// - Full PWM duty gives exactly the programmed current.
// - Lower PWM duty reduces the current of selected sinks.
// - The selection register picks which sinks follow the PWM input.
`timescale 1ns/1ps
module backlight_mode_ctrl
(
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Serial register port
    input wire logic scl_pin,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    // Reset pin and analog monitors
    input wire logic hardware_reset_pin_n,
    input wire logic undervoltage,
    input wire logic fault_detect,
    input wire logic vout_soft_start_done,
    input wire backlight_ctrl_pkg::headroom_type sink_headroom_voltage,
    // Image content PWM
    input wire logic image_pwm,
    // Power stage control
    output backlight_ctrl_pkg::op_mode_type op_mode,
    output logic circuits_enable,
    output logic i2c_receivers_enable,
    output logic soft_start_current_enable,
    output backlight_ctrl_pkg::gain_type gain,
    output backlight_ctrl_pkg::cp_switch_type cp_switch,
    output backlight_ctrl_pkg::sink_codes_type sink_current_code
);
    import backlight_ctrl_pkg::*;

    function automatic logic [CODE_W-1:0] scale_code(input logic [CODE_W-1:0] code, input logic [PWM_WIN_LOG2:0] duty);
        logic [CODE_W+PWM_WIN_LOG2:0] prod;
        prod = {{(PWM_WIN_LOG2+1){1'b0}}, code} * {{CODE_W{1'b0}}, duty};
        scale_code = prod[CODE_W+PWM_WIN_LOG2-1:PWM_WIN_LOG2];
    endfunction

    function automatic logic [7:0] read_mux(input logic [7:0] addr, input logic [7:0] mode_ctrl,
        input logic [NUM_SINKS-1:0] sel, input logic [CODE_W-1:0] level, input logic [NUM_SINKS-1:0] en,
        input logic [7:0] status);
        if (addr == REG_MODE_CTRL)
            read_mux = mode_ctrl;
        else if (addr == REG_IMG_SCALE_SEL)
            read_mux = {1'b0, sel};
        else if (addr == REG_LED_LEVEL)
            read_mux = {1'b0, level};
        else if (addr == REG_SINK_ENABLE)
            read_mux = {1'b0, en};
        else if (addr == REG_STATUS)
            read_mux = status;
        else
            read_mux = 8'h00;
    endfunction

    // Two-stage synchroniser; left unreset so that idle-high pins give no false edge after reset.
    logic [SYNC_W-1:0] sync1_ff;
    logic [SYNC_W-1:0] sync2_ff;
    wire [SYNC_W-1:0] pins_raw = {scl_pin, sda_in, hardware_reset_pin_n, undervoltage, fault_detect,
        vout_soft_start_done, image_pwm, sink_headroom_voltage};
    always_ff @(posedge mclk)
    begin
        sync1_ff <= pins_raw;
        sync2_ff <= sync1_ff;
    end
    wire scl_s = sync2_ff[SYNC_W-1];
    wire sda_s = sync2_ff[SYNC_W-2];
    wire rst_n_s = sync2_ff[SYNC_W-3];
    wire uv_s = sync2_ff[SYNC_W-4];
    wire fault_s = sync2_ff[SYNC_W-5];
    wire ss_done_s = sync2_ff[SYNC_W-6];
    wire pwm_s = sync2_ff[SYNC_W-7];
    headroom_type head_s;
    assign head_s = sync2_ff[2*NUM_SINKS-1:0];

    // Reset pin noise filter.
    logic [CNT_W-1:0] rst_filt_ff;
    wire rst_low_f = (rst_filt_ff == RST_FILTER_CNT);
    wire [CNT_W-1:0] nxt_rst_filt = rst_n_s ? '0 : (rst_low_f ? rst_filt_ff : rst_filt_ff + 1'b1);
    always_ff @(posedge mclk)
    begin
        rst_filt_ff <= sys_rst ? '0 : nxt_rst_filt;
    end

    op_mode_type mode_ff;
    op_mode_type nxt_mode;
    logic [7:0] mode_ctrl_ff;
    wire active_req = mode_ctrl_ff[ACTIVE_BIT_POS];
    always_comb
    begin
        nxt_mode = mode_ff;
        case (mode_ff)
            MODE_SHUTDOWN: nxt_mode = MODE_POR;
            MODE_POR: nxt_mode = MODE_STANDBY;
            MODE_STANDBY: if (active_req && !rst_low_f) nxt_mode = MODE_SOFTSTART;
            MODE_SOFTSTART:
                if (!active_req || rst_low_f) nxt_mode = MODE_STANDBY;
                else if (ss_done_s && !fault_s) nxt_mode = MODE_ACTIVE;
            MODE_ACTIVE:
                if (!active_req || rst_low_f) nxt_mode = MODE_STANDBY;
                else if (fault_s) nxt_mode = MODE_SOFTSTART;
            default: nxt_mode = MODE_POR;
        endcase
        if (uv_s) nxt_mode = MODE_SHUTDOWN;
    end
    always_ff @(posedge mclk)
    begin
        mode_ff <= sys_rst ? MODE_POR : nxt_mode;
    end

    // Register clear on system reset, shutdown, power-on reset and filtered reset pin.
    wire regs_clear = sys_rst || (mode_ff == MODE_POR) || (mode_ff == MODE_SHUTDOWN) || rst_low_f;
    wire i2c_on = (mode_ff != MODE_SHUTDOWN) && (mode_ff != MODE_POR);
    wire i2c_live = i2c_on && !rst_low_f;

    // Serial slave.
    i2c_state_type i2c_ff;
    logic [3:0] bit_cnt_ff;
    logic [7:0] shift_ff;
    logic [7:0] ptr_ff;
    logic rw_ff;
    logic ack_ok_ff;
    logic sda_drive_ff;
    logic scl_d_ff;
    logic sda_d_ff;
    always_ff @(posedge mclk)
    begin
        scl_d_ff <= scl_s;
        sda_d_ff <= sda_s;
    end
    wire scl_rise = scl_s && !scl_d_ff;
    wire scl_fall = !scl_s && scl_d_ff;
    wire start_det = scl_s && scl_d_ff && sda_d_ff && !sda_s;
    wire stop_det = scl_s && scl_d_ff && !sda_d_ff && sda_s;
    wire byte_done = scl_fall && (bit_cnt_ff == I2C_BYTE_BITS);
    wire addr_hit = (shift_ff[7:1] == I2C_DEV_ADDR);
    wire reg_wr = (i2c_ff == I2C_WR) && byte_done;
    logic [NUM_SINKS-1:0] img_sel_ff;
    logic [NUM_SINKS-1:0] sink_en_ff;
    logic [CODE_W-1:0] level_ff;
    gain_type gain_ff;
    wire [7:0] status_val = {gain_ff, mode_ff};
    wire [7:0] rd_data = read_mux(ptr_ff, mode_ctrl_ff, img_sel_ff, level_ff, sink_en_ff, status_val);
    wire receiving = (i2c_ff == I2C_ADDR) || (i2c_ff == I2C_PTR) || (i2c_ff == I2C_WR);

    always_ff @(posedge mclk)
    begin
        if (sys_rst || !i2c_live || stop_det)
        begin
            i2c_ff <= I2C_IDLE;
            bit_cnt_ff <= '0;
            sda_drive_ff <= 1'b0;
        end
        else if (start_det)
        begin
            i2c_ff <= I2C_ADDR;
            bit_cnt_ff <= '0;
            sda_drive_ff <= 1'b0;
        end
        else if (receiving && scl_rise)
        begin
            shift_ff <= {shift_ff[6:0], sda_s};
            bit_cnt_ff <= bit_cnt_ff + 1'b1;
        end
        else if (receiving && byte_done)
        begin
            bit_cnt_ff <= '0;
            sda_drive_ff <= (i2c_ff != I2C_ADDR) || addr_hit;
            case (i2c_ff)
                I2C_ADDR: i2c_ff <= addr_hit ? I2C_ADDR_ACK : I2C_IDLE;
                I2C_PTR: i2c_ff <= I2C_PTR_ACK;
                default: i2c_ff <= I2C_WR_ACK;
            endcase
            rw_ff <= shift_ff[0];
            if (i2c_ff == I2C_PTR) ptr_ff <= shift_ff;
        end
        else if (scl_fall)
        begin
            case (i2c_ff)
                I2C_ADDR_ACK:
                begin
                    i2c_ff <= rw_ff ? I2C_RD : I2C_PTR;
                    shift_ff <= rd_data;
                    sda_drive_ff <= rw_ff && !rd_data[7];
                end
                I2C_PTR_ACK, I2C_WR_ACK:
                begin
                    i2c_ff <= I2C_WR;
                    sda_drive_ff <= 1'b0;
                    if (i2c_ff == I2C_WR_ACK) ptr_ff <= ptr_ff + 1'b1;
                end
                I2C_RD:
                begin
                    bit_cnt_ff <= bit_cnt_ff + 1'b1;
                    shift_ff <= {shift_ff[6:0], 1'b0};
                    sda_drive_ff <= (bit_cnt_ff != I2C_LAST_BIT) && !shift_ff[6];
                    if (bit_cnt_ff == I2C_LAST_BIT) i2c_ff <= I2C_RD_ACK;
                end
                I2C_RD_ACK:
                begin
                    i2c_ff <= ack_ok_ff ? I2C_RD : I2C_IDLE;
                    bit_cnt_ff <= '0;
                    shift_ff <= rd_data;
                    sda_drive_ff <= ack_ok_ff && !rd_data[7];
                end
                default: i2c_ff <= i2c_ff;
            endcase
        end
        else if ((i2c_ff == I2C_RD_ACK) && scl_rise)
        begin
            ack_ok_ff <= !sda_s;
            if (!sda_s) ptr_ff <= ptr_ff + 1'b1;
        end
    end
    assign sda_out = 1'b0;
    assign sda_oe_n = !sda_drive_ff;

    // Register file.
    always_ff @(posedge mclk)
    begin
        // Defaults held through and after reset.
        if (regs_clear)
        begin
            mode_ctrl_ff <= MODE_CTRL_RST;
            img_sel_ff <= IMG_SEL_RST;
            sink_en_ff <= SINK_EN_RST;
            level_ff <= LED_LEVEL_RST;
        end
        else if (reg_wr)
        begin
            if (ptr_ff == REG_MODE_CTRL) mode_ctrl_ff <= shift_ff;
            else if (ptr_ff == REG_IMG_SCALE_SEL) img_sel_ff <= shift_ff[NUM_SINKS-1:0];
            else if (ptr_ff == REG_LED_LEVEL) level_ff <= shift_ff[CODE_W-1:0];
            else if (ptr_ff == REG_SINK_ENABLE) sink_en_ff <= shift_ff[NUM_SINKS-1:0];
        end
    end

    // Automatic gain selection.
    logic [CNT_W-1:0] settle_ff;
    wire need_up = |(head_s.below_min & sink_en_ff);
    wire can_down = ((head_s.above_max & sink_en_ff) == sink_en_ff) && !need_up;
    wire decide = (mode_ff == MODE_ACTIVE) && (settle_ff == '0);
    gain_type nxt_gain;
    always_comb
    begin
        nxt_gain = gain_ff;
        case (gain_ff)
            GAIN_1X: if (decide && need_up) nxt_gain = GAIN_1P5X;
            GAIN_1P5X:
                if (decide && need_up) nxt_gain = GAIN_2X;
                else if (decide && can_down) nxt_gain = GAIN_1X;
            GAIN_2X: if (decide && can_down) nxt_gain = GAIN_1P5X;
            default: nxt_gain = GAIN_1X;
        endcase
        if (mode_ff != MODE_ACTIVE) nxt_gain = GAIN_1X;
    end
    wire [CNT_W-1:0] nxt_settle = (mode_ff != MODE_ACTIVE) ? '0 :
        (nxt_gain != gain_ff) ? GAIN_SETTLE_CNT : (settle_ff == '0) ? '0 : settle_ff - 1'b1;
    always_ff @(posedge mclk)
    begin
        gain_ff <= sys_rst ? GAIN_1X : nxt_gain;
        settle_ff <= sys_rst ? '0 : nxt_settle;
    end

    // Image PWM duty measurement over a fixed window.
    logic [PWM_WIN_LOG2-1:0] win_ff;
    logic [PWM_WIN_LOG2:0] high_ff;
    logic [PWM_WIN_LOG2:0] duty_ff;
    wire win_end = (win_ff == PWM_WIN_LAST);
    wire [PWM_WIN_LOG2:0] high_inc = high_ff + {{PWM_WIN_LOG2{1'b0}}, pwm_s};
    always_ff @(posedge mclk)
    begin
        win_ff <= sys_rst ? '0 : win_ff + 1'b1;
        high_ff <= (sys_rst || win_end) ? '0 : high_inc;
        duty_ff <= sys_rst ? PWM_FULL : (win_end ? high_inc : duty_ff);
    end

    // Per-sink current codes.
    sink_codes_type nxt_codes;
    sink_codes_type codes_ff;
    always_comb
    begin
        for (int i = 0; i < NUM_SINKS; i++)
        begin
            nxt_codes[i] = (mode_ff != MODE_ACTIVE || !sink_en_ff[i]) ? '0 :
                (img_sel_ff[i] && duty_ff != PWM_FULL) ? scale_code(level_ff, duty_ff) : level_ff;
        end
    end
    always_ff @(posedge mclk)
    begin
        codes_ff <= sys_rst ? '0 : nxt_codes;
    end

    // Outputs.
    assign op_mode = mode_ff;
    assign gain = gain_ff;
    assign sink_current_code = codes_ff;
    assign circuits_enable = (mode_ff == MODE_ACTIVE) || (mode_ff == MODE_SOFTSTART);
    assign i2c_receivers_enable = i2c_on;
    // Limited charge current in soft start.
    assign soft_start_current_enable = (mode_ff == MODE_SOFTSTART) && !fault_s;
    // Switch network from gain, open on fault.
    wire pump_on = (mode_ff == MODE_ACTIVE) && !fault_s;
    assign cp_switch.bypass = pump_on && (gain_ff == GAIN_1X);
    assign cp_switch.charge_series = pump_on && (gain_ff == GAIN_1P5X);
    assign cp_switch.charge_parallel = pump_on && (gain_ff == GAIN_2X);
    assign cp_switch.discharge_parallel = pump_on && (gain_ff != GAIN_1X);

    // Checks.
    AST_ACTIVE_NEEDS_BIT: assert property (@(posedge mclk) disable iff (sys_rst)
        (mode_ff == MODE_ACTIVE) |-> $past(active_req)) else $error("Active mode without active bit.");
    AST_STANDBY_OFF: assert property (@(posedge mclk) disable iff (sys_rst)
        (mode_ff == MODE_STANDBY) |-> (!circuits_enable && i2c_receivers_enable)) else $error("Standby power wrong.");
    AST_BIT_CLEAR_STANDBY: assert property (@(posedge mclk) disable iff (sys_rst)
        (mode_ff == MODE_ACTIVE && !active_req && !uv_s) |=> (mode_ff == MODE_STANDBY)) else $error("No standby.");
    AST_SOFTSTART_FIRST: assert property (@(posedge mclk) disable iff (sys_rst)
        $rose(mode_ff == MODE_ACTIVE) |-> ($past(mode_ff) == MODE_SOFTSTART)) else $error("Active without soft start.");
    AST_UV_SHUTDOWN: assert property (@(posedge mclk) disable iff (sys_rst)
        uv_s |=> (mode_ff == MODE_SHUTDOWN && !i2c_receivers_enable)) else $error("No shutdown on undervoltage.");
    AST_POR_SEQUENCE: assert property (@(posedge mclk) disable iff (sys_rst)
        (mode_ff == MODE_SHUTDOWN && !uv_s) ##1 !uv_s |=> (mode_ff == MODE_STANDBY && mode_ctrl_ff == MODE_CTRL_RST))
        else $error("Power-on reset sequence wrong.");
    AST_RST_NO_ACK: assert property (@(posedge mclk) disable iff (sys_rst)
        rst_low_f |=> (!sda_drive_ff && mode_ctrl_ff == MODE_CTRL_RST)) else $error("Acknowledge during reset pin.");
    AST_RST_FILTER: assert property (@(posedge mclk) disable iff (sys_rst)
        $rose(rst_low_f) |-> ($past(rst_filt_ff) == RST_FILTER_CNT - 1'b1 && !$past(rst_n_s)))
        else $error("Reset pin filter short.");
    AST_UNITY_START: assert property (@(posedge mclk) disable iff (sys_rst)
        $rose(mode_ff == MODE_ACTIVE) |-> (gain_ff == GAIN_1X)) else $error("Gain not unity at start.");
    AST_GAIN_UP: assert property (@(posedge mclk) disable iff (sys_rst)
        (decide && need_up && gain_ff == GAIN_1X && nxt_mode == MODE_ACTIVE) |=>
        (gain_ff == GAIN_1P5X && settle_ff == GAIN_SETTLE_CNT)) else $error("Gain did not rise.");
    AST_SETTLE_HOLD: assert property (@(posedge mclk) disable iff (sys_rst)
        (settle_ff != '0 && mode_ff == MODE_ACTIVE) |=> ($stable(gain_ff) || mode_ff != MODE_ACTIVE))
        else $error("Gain changed while settling.");
    AST_FAULT_OPEN: assert property (@(posedge mclk) disable iff (sys_rst)
        fault_s |-> (cp_switch == '0)) else $error("Switches closed in fault.");
    AST_FULL_DUTY: assert property (@(posedge mclk) disable iff (sys_rst)
        (duty_ff == PWM_FULL && mode_ff == MODE_ACTIVE && sink_en_ff[1] && $stable(level_ff)) |=>
        (codes_ff[1] == $past(level_ff))) else $error("Full duty scaled current.");
    COV_GAIN_2X: cover property (@(posedge mclk) disable iff (sys_rst) gain_ff == GAIN_2X);
    COV_RST_PIN: cover property (@(posedge mclk) disable iff (sys_rst) $rose(rst_low_f));
    COV_REG_WRITE: cover property (@(posedge mclk) disable iff (sys_rst) reg_wr && ptr_ff == REG_IMG_SCALE_SEL);
endmodule // backlight_mode_ctrl

/* bench/i2c_host_model.sv */
// Serial bus host model that writes and reads registers of the controller.
`timescale 1ns/1ps
module i2c_host_model
(
    // Clock
    input wire logic mclk,
    // Serial bus wire
    input wire logic sda_oe_n,
    output logic scl,
    output logic sda_lvl
);
    import backlight_ctrl_pkg::*;
    localparam int HALF = 12;
    logic m_sda = 1'h1;
    initial scl = 1'h1;
    // The wire is pulled up, so either party may pull it low.
    assign sda_lvl = m_sda & sda_oe_n;
    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask
    // A start is frame(1, 0) and a stop is frame(0, 1).
    task automatic frame(input logic a, input logic b);
        cyc(HALF / 2);
        m_sda = a;
        cyc(HALF / 2);
        scl = 1'h1;
        cyc(HALF);
        m_sda = b;
        cyc(HALF);
        scl = b;
    endtask
    task automatic bit_x(input logic v, output logic s);
        cyc(HALF / 2);
        m_sda = v;
        cyc(HALF / 2);
        scl = 1'h1;
        cyc(HALF);
        s = sda_lvl;
        scl = 1'h0;
    endtask
    task automatic byte_x(input logic [7:0] b, output logic [7:0] r, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_x(b[i], r[i]);
        bit_x(1'h1, s);
        ack = !s;
    endtask
    task automatic access(input logic [7:0] a, input logic [7:0] d, input logic rd, output logic [7:0] q,
        output logic ack);
        logic a0, a1, a2, s;
        frame(1'h1, 1'h0);
        byte_x({I2C_DEV_ADDR, 1'h0}, q, a0);
        byte_x(a, q, a1);
        if (rd)
            frame(1'h1, 1'h0);
        byte_x(rd ? {I2C_DEV_ADDR, 1'h1} : d, q, a2);
        if (rd)
            byte_x(8'hff, q, s);
        frame(1'h0, 1'h1);
        ack = a0 & a1 & a2;
    endtask
endmodule // i2c_host_model

/* bench/tb_backlight_mode_ctrl.sv */
// Self-checking testbench of the backlight mode, gain and image scaling controller.
`timescale 1ns/1ps
module tb_backlight_mode_ctrl;
    import backlight_ctrl_pkg::*;
    logic mclk = 1'h0;
    logic sys_rst = 1'h1;
    logic hardware_reset_pin_n = 1'h1;
    logic undervoltage = 1'h0;
    logic fault_detect = 1'h0;
    logic ss_done = 1'h0;
    logic image_pwm = 1'h0;
    headroom_type headroom = '0;
    logic scl, sda_lvl, sda_out, sda_oe_n, circuits_enable, rx_enable, ss_cur_en, ack;
    op_mode_type op_mode;
    gain_type gain;
    cp_switch_type cp_switch;
    sink_codes_type codes;
    logic [7:0] q, level, sel;
    int n_fail = 0;
    int num_checks = 0;
    int cycles = 0;
    int duty = 0;
    i2c_host_model i2c_host_model_i (.mclk(mclk), .sda_oe_n(sda_oe_n | sda_out), .scl(scl), .sda_lvl(sda_lvl));
    backlight_mode_ctrl backlight_mode_ctrl_i (.mclk(mclk), .sys_rst(sys_rst), .scl_pin(scl), .sda_in(sda_lvl),
        .sda_out(sda_out), .sda_oe_n(sda_oe_n), .hardware_reset_pin_n(hardware_reset_pin_n),
        .undervoltage(undervoltage), .fault_detect(fault_detect), .vout_soft_start_done(ss_done),
        .sink_headroom_voltage(headroom), .image_pwm(image_pwm), .op_mode(op_mode),
        .circuits_enable(circuits_enable), .i2c_receivers_enable(rx_enable), .soft_start_current_enable(ss_cur_en),
        .gain(gain), .cp_switch(cp_switch), .sink_current_code(codes));
    initial forever #12.5 mclk = ~mclk;
    // A 16-cycle period fits a whole number of times into each duty window.
    always @(negedge mclk) image_pwm <= (cycles % 16) < duty;
    always @(posedge mclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 90000)
        begin
            mismatch("timeout");
            wrap_up();
        end
    end
    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask
    task automatic mismatch(input string msg);
        $display("MISMATCH at %0t: %s", $time, msg);
        n_fail++;
    endtask
    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp)
            mismatch($sformatf("read %h, expected %h", got, exp));
    endtask
    task automatic chk_port(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp)
            mismatch($sformatf("port %h, expected %h", got, exp));
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i2c_host_model_i.access(a, d, 1'h0, q, ack);
        chk_port(16'(ack), 16'h0001);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        i2c_host_model_i.access(a, 8'h00, 1'h1, q, ack);
        chk_port(16'(ack), 16'h0001);
        chk_reg(q, exp);
    endtask
    function automatic logic [6:0] exp_code(input logic [6:0] lv, input int k);
        return 7'((lv * k * 256) >> 12);
    endfunction
    function automatic logic [6:0] exp_sink(input int i, input int k);
        return (i == 0) ? 7'h00 : sel[i] ? exp_code(level[6:0], k) : level[6:0];
    endfunction
    task automatic wrap_up;
        if (n_fail == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial
    begin
        void'($urandom(36727));
        cyc(5);
        sys_rst = 1'h0;
        cyc(6);
        chk_port(16'({op_mode, circuits_enable, rx_enable}), 16'({MODE_STANDBY, 2'h1}));
        rd(REG_IMG_SCALE_SEL, 8'(IMG_SEL_RST));
        rd(REG_SINK_ENABLE, 8'(SINK_EN_RST));
        rd(REG_STATUS, {GAIN_1X, MODE_STANDBY});
        rd(8'h30, 8'h00);
        sel = 8'($urandom_range(127, 0));
        level = 8'($urandom_range(127, 1));
        wr(REG_IMG_SCALE_SEL, sel);
        wr(REG_LED_LEVEL, level);
        rd(REG_LED_LEVEL, {1'h0, level[6:0]});
        wr(REG_SINK_ENABLE, 8'h7e);
        rd(REG_IMG_SCALE_SEL, sel);
        wr(REG_MODE_CTRL, 8'h01);
        cyc(5);
        chk_port(16'({op_mode, ss_cur_en, cp_switch}), 16'({MODE_SOFTSTART, 5'h10}));
        ss_done = 1'h1;
        cyc(6);
        chk_port(16'({op_mode, gain, cp_switch}), 16'({MODE_ACTIVE, GAIN_1X, 4'h8}));
        headroom = {7'h02, 7'h00};
        cyc(6);
        chk_port(16'({gain, cp_switch}), 16'({GAIN_1P5X, 4'h5}));
        cyc(3975);
        chk_port(16'(gain), 16'(GAIN_1P5X));
        cyc(40);
        chk_port(16'({gain, cp_switch}), 16'({GAIN_2X, 4'h3}));
        headroom = {7'h01, 7'h7e};
        cyc(4030);
        chk_port(16'(gain), 16'(GAIN_1P5X));
        headroom = '0;
        for (int d = 0; d < 3; d++)
        begin
            duty = (d == 0) ? 16 : (d == 1) ? int'($urandom_range(15, 1)) : 0;
            cyc(8300);
            for (int i = 0; i < NUM_SINKS; i++)
                chk_port(16'(codes[i]), 16'(exp_sink(i, duty)));
        end
        fault_detect = 1'h1;
        cyc(5);
        chk_port(16'({op_mode, cp_switch, ss_cur_en}), 16'({MODE_SOFTSTART, 5'h00}));
        fault_detect = 1'h0;
        cyc(6);
        chk_port(16'({op_mode, gain}), 16'({MODE_ACTIVE, GAIN_1X}));
        wr(REG_MODE_CTRL, 8'h00);
        cyc(4);
        chk_port(16'({op_mode, circuits_enable, rx_enable}), 16'({MODE_STANDBY, 2'h1}));
        wr(REG_MODE_CTRL, 8'h01);
        hardware_reset_pin_n = 1'h0;
        cyc(1000);
        hardware_reset_pin_n = 1'h1;
        cyc(6);
        chk_port(16'(op_mode), 16'(MODE_ACTIVE));
        hardware_reset_pin_n = 1'h0;
        cyc(2100);
        chk_port(16'(op_mode), 16'(MODE_STANDBY));
        i2c_host_model_i.access(REG_IMG_SCALE_SEL, 8'h55, 1'h0, q, ack);
        chk_port(16'(ack), 16'h0000);
        hardware_reset_pin_n = 1'h1;
        cyc(6);
        rd(REG_IMG_SCALE_SEL, 8'(IMG_SEL_RST));
        chk_port(16'(op_mode), 16'(MODE_STANDBY));
        wr(REG_SINK_ENABLE, 8'h00);
        undervoltage = 1'h1;
        cyc(6);
        chk_port(16'({op_mode, rx_enable}), 16'({MODE_SHUTDOWN, 1'h0}));
        i2c_host_model_i.access(REG_SINK_ENABLE, 8'h11, 1'h0, q, ack);
        chk_port(16'(ack), 16'h0000);
        undervoltage = 1'h0;
        cyc(6);
        chk_port(16'(op_mode), 16'(MODE_STANDBY));
        rd(REG_SINK_ENABLE, 8'(SINK_EN_RST));
        wrap_up();
    end
endmodule // tb_backlight_mode_ctrl
